/* File: pic_pkg.sv */
`default_nettype none
package pic_pkg;
	// source count, polling order is index order
	localparam int          NUM_SRC      = 8;
	localparam int          LVL_W        = 2;
	localparam int          ADDR_W       = 5;
	localparam int          IDX_W        = 3;
	localparam int          RANK_W       = 3;
	localparam int          ISR_W        = 5;
	localparam int          EV_W         = 4;
	localparam int          TIMER0_IDX   = 1;
	// vectors: base plus step times source index
	localparam logic [15:0] VEC_BASE     = 16'h0003;
	localparam logic [15:0] VEC_STEP     = 16'h0008;
	localparam logic [15:0] TIMER0_VEC   = 16'h000B;
	localparam logic [15:0] NMI_VEC      = 16'h0073;
	// sources whose flag the vector fetch clears
	localparam logic [7:0]  AUTOCLR_MASK = 8'h02;
	// ranks: main, levels 0..3, nmi
	localparam logic [2:0]  RANK_MAIN    = 3'h0;
	localparam logic [2:0]  RANK_NMI     = 3'h5;
	localparam int          ISR_NMI_BIT  = 4;
	// register byte offsets
	localparam logic [4:0]  OFS_FLAG     = 5'h00;
	localparam logic [4:0]  OFS_ENABLE   = 5'h04;
	localparam logic [4:0]  OFS_PRIO     = 5'h08;
	localparam logic [4:0]  OFS_INSERV   = 5'h0C;
	localparam logic [4:0]  OFS_EVSTAT   = 5'h10;
	localparam logic [4:0]  OFS_EVMASK   = 5'h14;
	localparam logic [4:0]  OFS_SWSET    = 5'h18;
	// event status bit positions
	localparam int          EV_VEC       = 0;
	localparam int          EV_NMI       = 1;
	localparam int          EV_PREEMPT   = 2;
	localparam int          EV_BADRET    = 3;
	// reset values
	localparam logic [7:0]  FLAG_RST     = 8'h00;
	localparam logic [7:0]  ENABLE_RST   = 8'h00;
	localparam logic [15:0] PRIO_RST     = 16'h0000;
	localparam logic [3:0]  EVMASK_RST   = 4'h0;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_REQ  = 2'b10
	} pic_state_type;
endpackage
`default_nettype wire

/* File: pic_arb_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface pic_arb_if;
	import pic_pkg::*;
	logic [NUM_SRC-1:0]       pend;
	logic [NUM_SRC*LVL_W-1:0] prio;
	logic                     nmi;
	logic [RANK_W-1:0]        cur_rank;
	logic                     win;
	logic [IDX_W-1:0]         win_idx;
	logic                     win_nmi;
	logic [RANK_W-1:0]        win_rank;
	modport ctl (output pend, prio, nmi, cur_rank, input win, win_idx, win_nmi, win_rank);
	modport arb (input pend, prio, nmi, cur_rank, output win, win_idx, win_nmi, win_rank);
endinterface
`default_nettype wire

/* File: pic_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
module pic_arbiter (
	// request view from the controller
	pic_arb_if.arb arb
);
	import pic_pkg::*;

	logic [RANK_W-1:0] src_rank [NUM_SRC];
	logic [RANK_W-1:0] best_rank;
	logic [IDX_W-1:0]  best_idx;

	////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi = gi + 1) begin : g_rank
			// any of four levels per source
			assign src_rank[gi] = arb.pend[gi] ?
				RANK_W'({1'b0, arb.prio[gi*LVL_W +: LVL_W]} + 3'h1) : RANK_MAIN;
		end
	endgenerate

	// strict compare keeps the lowest index on a tie
	always_comb begin
		best_rank = RANK_MAIN;
		best_idx  = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (src_rank[i] > best_rank) begin
				best_rank = src_rank[i];
				best_idx  = IDX_W'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// nmi has a fixed rank above level three
	assign arb.win_nmi  = arb.nmi;
	assign arb.win_rank = arb.nmi ? RANK_NMI : best_rank;
	assign arb.win_idx  = best_idx;
	assign arb.win      = arb.win_rank > arb.cur_rank;
endmodule
`default_nettype wire

/* File: pic_ctrl.sv */
// Summary of operation
// - each source takes one of four levels
// - only strictly higher rank preempts a handler
// - nmi always ranks above level three
// - highest pending level is vectored first
// - lowest index wins within one level
// - timer0 vectors to 000B when enabled
// - timer0 flag cleared when it is vectored
// - acknowledge via long call, psw not saved
// - interrupt return ends current in-service level
// - plain return leaves in-service level set
// - other flags stay until software clears
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pic_ctrl (
	// clock and reset
	input  wire logic                          sys_clk_in,
	input  wire logic                          reset_n_in,
	input  wire logic                          clk_en_in,
	// avalon-mm slave
	input  wire logic [pic_pkg::ADDR_W-1:0]    avs_address_in,
	input  wire logic                          avs_read_in,
	input  wire logic                          avs_write_in,
	input  wire logic [31:0]                   avs_writedata_in,
	output logic      [31:0]                   avs_readdata_out,
	output logic                               avs_waitrequest_out,
	// request sources, same clock
	input  wire logic [pic_pkg::NUM_SRC-1:0]   src_event_in,
	input  wire logic                          nmi_event_in,
	// core side
	output logic                               irq_req_out,
	output logic      [15:0]                   irq_vector_out,
	output logic      [pic_pkg::RANK_W-1:0]    irq_rank_out,
	input  wire logic                          irq_ack_in,
	input  wire logic                          irq_return_in,
	// event interrupt
	output logic                               irq_out
);
	import pic_pkg::*;

	pic_arb_if arb_bus ();

	pic_state_type             state_ff, nxt_state;
	logic [NUM_SRC-1:0]        flag_ff, nxt_flag;
	logic [NUM_SRC-1:0]        en_ff, nxt_en;
	logic [NUM_SRC*LVL_W-1:0]  prio_ff, nxt_prio;
	logic [ISR_W-1:0]          isr_ff, nxt_isr;
	logic [EV_W-1:0]           ev_ff, nxt_ev;
	logic [EV_W-1:0]           mask_ff, nxt_mask;
	logic                      nmi_ff, nxt_nmi;
	logic [IDX_W-1:0]          idx_ff, nxt_idx;
	logic                      rnmi_ff, nxt_rnmi;
	logic [RANK_W-1:0]         rank_ff, nxt_rank;
	logic [15:0]               vec_ff, nxt_vec;
	logic                      req_ff, nxt_req;
	logic                      wait_ff, nxt_wait;
	logic [31:0]               rdata_ff, nxt_rdata;
	logic                      int_ff, nxt_int;

	////////////////////////////////////////////////////////////////
	// bus decode
	wire bus_req  = avs_read_in | avs_write_in;
	wire acc_done = bus_req & ~wait_ff;
	wire wr_go    = avs_write_in & acc_done;
	wire sel_flag = avs_address_in == OFS_FLAG;
	wire sel_en   = avs_address_in == OFS_ENABLE;
	wire sel_prio = avs_address_in == OFS_PRIO;
	wire sel_isr  = avs_address_in == OFS_INSERV;
	wire sel_ev   = avs_address_in == OFS_EVSTAT;
	wire sel_mask = avs_address_in == OFS_EVMASK;
	wire sel_set  = avs_address_in == OFS_SWSET;

	// unmapped offsets read as zero
	wire [31:0] rd_mux =
		sel_flag ? {24'h000000, flag_ff} :
		sel_en   ? {24'h000000, en_ff} :
		sel_prio ? {16'h0000, prio_ff} :
		sel_isr  ? {27'h0000000, isr_ff} :
		sel_ev   ? {28'h0000000, ev_ff} :
		sel_mask ? {28'h0000000, mask_ff} : 32'h00000000;

	// one wait cycle: data is registered while waitrequest is high
	assign nxt_wait  = ~(bus_req & wait_ff);
	assign nxt_rdata = (bus_req & wait_ff) ? rd_mux : rdata_ff;

	////////////////////////////////////////////////////////////////
	// ranks and arbitration
	function automatic logic [RANK_W-1:0] top_rank(input logic [ISR_W-1:0] s);
		logic [RANK_W-1:0] r;
		r = RANK_MAIN;
		for (int i = 0; i < ISR_W; i++) begin
			if (s[i]) begin
				r = RANK_W'(i + 1);
			end
		end
		return r;
	endfunction

	wire [RANK_W-1:0] cur_rank = top_rank(isr_ff);
	wire [NUM_SRC-1:0] pend   = flag_ff & en_ff;

	assign arb_bus.pend     = pend;
	assign arb_bus.prio     = prio_ff;
	assign arb_bus.nmi      = nmi_ff;
	assign arb_bus.cur_rank = cur_rank;

	pic_arbiter u_arb (
		.arb (arb_bus)
	);

	////////////////////////////////////////////////////////////////
	// handshake with the core
	wire take    = (state_ff == ST_IDLE) & arb_bus.win;
	wire ack     = (state_ff == ST_REQ) & irq_ack_in;
	// a source cleared or disabled before the fetch withdraws its request
	wire gone    = (state_ff == ST_REQ) & ~rnmi_ff & ~pend[idx_ff];
	wire [NUM_SRC-1:0] idx_hot = NUM_SRC'(1) << idx_ff;
	wire [NUM_SRC-1:0] hw_clr  = (ack & ~rnmi_ff) ? (idx_hot & AUTOCLR_MASK) : '0;
	wire [ISR_W-1:0] ack_set   = ack ? ISR_W'(5'h01 << (rank_ff - 3'h1)) : '0;
	wire ret_ok  = irq_return_in & (cur_rank != RANK_MAIN);
	wire [ISR_W-1:0] ret_clr   = ret_ok ? ISR_W'(5'h01 << (cur_rank - 3'h1)) : '0;

	wire [15:0] src_vec = 16'(VEC_BASE + VEC_STEP * {13'h0000, arb_bus.win_idx});

	always_comb begin
		nxt_state = state_ff;
		nxt_req   = req_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = ST_REQ;
					nxt_req   = 1'b1;
				end
			end
			ST_REQ: begin
				if (ack || gone) begin
					nxt_state = ST_IDLE;
					nxt_req   = 1'b0;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_req   = 1'b0;
			end
		endcase
	end

	assign nxt_idx  = take ? arb_bus.win_idx : idx_ff;
	assign nxt_rnmi = take ? arb_bus.win_nmi : rnmi_ff;
	assign nxt_rank = take ? arb_bus.win_rank : rank_ff;
	assign nxt_vec  = take ? (arb_bus.win_nmi ? NMI_VEC : src_vec) : vec_ff;

	////////////////////////////////////////////////////////////////
	// flags: set wins over every clear
	wire [NUM_SRC-1:0] sw_clr = (wr_go & sel_flag) ? avs_writedata_in[NUM_SRC-1:0] : '0;
	wire [NUM_SRC-1:0] sw_set = (wr_go & sel_set) ? avs_writedata_in[NUM_SRC-1:0] : '0;
	assign nxt_flag = (flag_ff & ~sw_clr & ~hw_clr) | src_event_in | sw_set;
	assign nxt_nmi  = (nmi_ff & ~(ack & rnmi_ff)) | nmi_event_in;
	assign nxt_en   = (wr_go & sel_en) ? avs_writedata_in[NUM_SRC-1:0] : en_ff;
	assign nxt_prio = (wr_go & sel_prio) ? avs_writedata_in[NUM_SRC*LVL_W-1:0] : prio_ff;
	assign nxt_mask = (wr_go & sel_mask) ? avs_writedata_in[EV_W-1:0] : mask_ff;

	// only the interrupt return clears; a plain return has no path here
	assign nxt_isr = (isr_ff & ~ret_clr) | ack_set;

	// events
	wire [EV_W-1:0] ev_set = {irq_return_in & ~ret_ok, take & (cur_rank != RANK_MAIN),
		ack & rnmi_ff, ack};
	wire [EV_W-1:0] ev_clr = (wr_go & sel_ev) ? avs_writedata_in[EV_W-1:0] : '0;
	assign nxt_ev  = (ev_ff & ~ev_clr) | ev_set;
	// registered, so it trails the status by one cycle
	assign nxt_int = |(ev_ff & mask_ff);

	////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_ff <= ST_IDLE;
			req_ff   <= 1'b0;
			idx_ff   <= '0;
			rnmi_ff  <= 1'b0;
			rank_ff  <= RANK_MAIN;
			vec_ff   <= 16'h0000;
		end else if (clk_en_in) begin
			state_ff <= nxt_state;
			req_ff   <= nxt_req;
			idx_ff   <= nxt_idx;
			rnmi_ff  <= nxt_rnmi;
			rank_ff  <= nxt_rank;
			vec_ff   <= nxt_vec;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flag_ff <= FLAG_RST;
			nmi_ff  <= 1'b0;
			en_ff   <= ENABLE_RST;
			prio_ff <= PRIO_RST;
			isr_ff  <= '0;
		end else if (clk_en_in) begin
			flag_ff <= nxt_flag;
			nmi_ff  <= nxt_nmi;
			en_ff   <= nxt_en;
			prio_ff <= nxt_prio;
			isr_ff  <= nxt_isr;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ev_ff    <= '0;
			mask_ff  <= EVMASK_RST;
			int_ff   <= 1'b0;
			wait_ff  <= 1'b1;
			rdata_ff <= 32'h00000000;
		end else if (clk_en_in) begin
			ev_ff    <= nxt_ev;
			mask_ff  <= nxt_mask;
			int_ff   <= nxt_int;
			wait_ff  <= nxt_wait;
			rdata_ff <= nxt_rdata;
		end
	end

	assign avs_readdata_out    = rdata_ff;
	assign avs_waitrequest_out = wait_ff;
	assign irq_req_out         = req_ff;
	assign irq_vector_out      = vec_ff;
	assign irq_rank_out        = rank_ff;
	assign irq_out             = int_ff;

	////////////////////////////////////////////////////////////////
	// checks
	logic better_exists;
	always_comb begin
		better_exists = 1'b0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (pend[i]) begin
				if ({1'b0, prio_ff[i*LVL_W +: LVL_W]} + 3'h1 > arb_bus.win_rank ||
					({1'b0, prio_ff[i*LVL_W +: LVL_W]} + 3'h1 == arb_bus.win_rank &&
					IDX_W'(i) < arb_bus.win_idx)) begin
					better_exists = 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	level_rank_a: assert property (clk_en_in && take && !nmi_ff |=>
		rank_ff == 3'({1'b0, prio_ff[idx_ff*LVL_W +: LVL_W]} + 3'h1))
		else $error("vectored rank differs from programmed level");

	preempt_gate_a: assert property ($rose(req_ff) |-> rank_ff > $past(cur_rank))
		else $error("request raised without strictly higher rank");

	nmi_top_a: assert property (clk_en_in && state_ff == ST_IDLE && nmi_ff
		&& !isr_ff[ISR_NMI_BIT] |=> req_ff && rnmi_ff && irq_vector_out == NMI_VEC
		&& rank_ff == RANK_NMI)
		else $error("nmi not taken at top rank");

	poll_order_a: assert property (take && !nmi_ff |-> !better_exists)
		else $error("winner is not highest level lowest index");

	timer0_vec_a: assert property ($rose(req_ff) && !rnmi_ff && idx_ff == IDX_W'(TIMER0_IDX)
		|-> irq_vector_out == TIMER0_VEC && $past(en_ff[TIMER0_IDX]))
		else $error("timer0 vector or enable wrong");

	t0_autoclr_a: assert property (clk_en_in && ack && !rnmi_ff
		&& idx_ff == IDX_W'(TIMER0_IDX) && !src_event_in[TIMER0_IDX] && !sw_set[TIMER0_IDX]
		|=> !flag_ff[TIMER0_IDX])
		else $error("timer0 flag survived its vector fetch");

	ack_mark_a: assert property (clk_en_in && ack && !ret_ok |=>
		!req_ff && cur_rank == $past(rank_ff))
		else $error("acknowledge did not mark level in service");

	irq_return_insn_clear_a: assert property (clk_en_in && ret_ok && !ack |=>
		cur_rank < $past(cur_rank))
		else $error("interrupt return left level in service");

	ret_hold_a: assert property (clk_en_in && !irq_return_in |=>
		($past(isr_ff) & ~isr_ff) == '0)
		else $error("in-service level cleared without interrupt return");

	sw_flag_a: assert property (clk_en_in && ack && !rnmi_ff
		&& !AUTOCLR_MASK[idx_ff] && !sw_clr[idx_ff] |=> flag_ff[$past(idx_ff)])
		else $error("software-cleared flag dropped by hardware");

	enable_gate_a: assert property (take && !nmi_ff |->
		en_ff[arb_bus.win_idx] && flag_ff[arb_bus.win_idx])
		else $error("disabled or idle source was vectored");

	idle_no_offer_a: assert property (clk_en_in && state_ff == ST_IDLE && !arb_bus.win |=> !req_ff)
		else $error("request offered without a winning source");

	offer_hold_a: assert property (clk_en_in && req_ff && !ack && !gone |=>
		req_ff && $stable(irq_vector_out) && $stable(irq_rank_out))
		else $error("offered vector changed before the long call");

	offer_drop_a: assert property (clk_en_in && gone && !ack |=> !req_ff)
		else $error("withdrawn source still offered");

	nmi_sticky_a: assert property (clk_en_in && nmi_ff && !(ack && rnmi_ff) |=> nmi_ff)
		else $error("nmi request lost before it was taken");

	////////////////////////////////////////////////////////////////
	// flags, events, bus and clock enable
	flag_set_wins_a: assert property (clk_en_in && (src_event_in != '0) |=>
		(flag_ff & $past(src_event_in)) == $past(src_event_in))
		else $error("source event did not set its flag");

	flag_stay_a: assert property (clk_en_in && !(wr_go && sel_flag) && !ack |=>
		($past(flag_ff) & ~flag_ff) == '0)
		else $error("flag cleared without software or vector fetch");

	ev_sticky_a: assert property (clk_en_in && !(wr_go && sel_ev) |=>
		($past(ev_ff) & ~ev_ff) == '0)
		else $error("event status bit dropped without a clear");

	ack_event_a: assert property (clk_en_in && ack |=>
		ev_ff[EV_VEC] && (ev_ff[EV_NMI] || !$past(rnmi_ff)))
		else $error("vector fetch event not recorded");

	bad_return_a: assert property (clk_en_in && irq_return_in && cur_rank == RANK_MAIN && !ack |=>
		ev_ff[EV_BADRET] && isr_ff == '0)
		else $error("stray interrupt return not recorded");

	irq_follow_a: assert property (clk_en_in && (ev_ff & mask_ff) != '0 |=> irq_out)
		else $error("event interrupt missing for unmasked status");

	wait_answer_a: assert property (clk_en_in && bus_req && wait_ff |=>
		!wait_ff && avs_readdata_out == $past(rd_mux))
		else $error("bus answer missing after one wait cycle");

	wait_single_a: assert property (clk_en_in && !wait_ff |=> wait_ff)
		else $error("waitrequest low for more than one cycle");

	isr_readonly_a: assert property (clk_en_in && wr_go && sel_isr && !ack && !ret_ok |=>
		isr_ff == $past(isr_ff))
		else $error("in-service register changed by a bus write");

	freeze_a: assert property (!clk_en_in |=> $stable(state_ff) && $stable(flag_ff)
		&& $stable(isr_ff) && $stable(ev_ff) && $stable(wait_ff))
		else $error("state moved while clock enable was low");
endmodule
`default_nettype wire

/* File: pic_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pic_core_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// offer from the controller
	input  wire logic        req_in,
	input  wire logic [15:0] vec_in,
	input  wire logic [2:0]  rank_in,
	input  wire logic [3:0]  delay_in,
	// core answer
	output logic             ack_out,
	output logic      [15:0] vec_out,
	output logic      [2:0]  rank_out,
	output logic      [7:0]  taken_out
);
	logic [3:0] cnt_ff;
	//////////////////////////////////////////////////////////////////////////////
	// a slow core leaves the offer standing for delay_in + 1 cycles before the call
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff    <= 4'h0;
			ack_out   <= 1'h0;
			vec_out   <= 16'h0000;
			rank_out  <= 3'h0;
			taken_out <= 8'h00;
		end else if (ack_out || !req_in) begin
			ack_out <= 1'h0;
			cnt_ff  <= 4'h0;
		end else if (cnt_ff >= delay_in) begin
			// long call: vector loaded, status word not kept
			ack_out   <= 1'h1;
			vec_out   <= vec_in;
			rank_out  <= rank_in;
			taken_out <= taken_out + 8'h01;
		end else begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* File: tb_pic_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_pic_ctrl;
	import pic_pkg::*;
	logic        clk, rst_n, rd, wr, ret, nmi, ack, wreq, irq, req, ce;
	logic [4:0]  adr;
	logic [31:0] wd, rdat, q;
	logic [7:0]  src, taken;
	logic [15:0] vec, cvec;
	logic [2:0]  rank, crank;
	logic [3:0]  dly;
	int          n_fail, compares, j;
	pic_ctrl i_dut (.sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(ce),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .src_event_in(src), .nmi_event_in(nmi),
		.irq_req_out(req), .irq_vector_out(vec), .irq_rank_out(rank), .irq_ack_in(ack),
		.irq_return_in(ret), .irq_out(irq));
	pic_core_model i_core (.clk_in(clk), .rst_n_in(rst_n), .req_in(req), .vec_in(vec), .rank_in(rank),
		.delay_in(dly), .ack_out(ack), .vec_out(cvec), .rank_out(crank), .taken_out(taken));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	//////////////////////////////////////////////////////////////////////////////
	task test_done;
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task bad(input string m);
		n_fail++;
		$display("BAD %0t %s", $time, m);
	endtask
	task chk_reg(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) bad($sformatf("value %h expected %h", g, e));
	endtask
	task chk_irq(input logic [15:0] v, input logic [2:0] r);
		compares++;
		if (cvec !== v || crank !== r) bad($sformatf("vector %h rank %h expected %h %h", cvec, crank, v, r));
	endtask
	// one access, held until waitrequest is seen low
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		rd  <= !w;
		wr  <= w;
		adr <= a;
		wd  <= d;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (wreq === 1'h0) break;
		end
		if (k < 20) begin
			q = rdat;
			rd <= 1'h0;
			wr <= 1'h0;
		end else begin
			bad("bus timeout");
			test_done;
		end
	endtask
	task rdc(input logic [4:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk_reg(q, e);
	endtask
	task pulse(input logic [7:0] s, input logic n, input logic r);
		@(posedge clk);
		src <= s;
		nmi <= n;
		ret <= r;
		@(posedge clk);
		src <= 8'h00;
		nmi <= 1'h0;
		ret <= 1'h0;
	endtask
	task take(input logic [15:0] v, input logic [2:0] r);
		logic [7:0] t0;
		int k;
		t0 = taken;
		for (k = 0; k < 60 && taken === t0; k++) @(posedge clk);
		if (k < 60) begin
			chk_irq(v, r);
		end else begin
			bad("no vector taken");
			test_done;
		end
	endtask
	task no_take;
		logic [7:0] t0;
		t0 = taken;
		repeat (12) @(posedge clk);
		chk_reg({24'h0, taken}, {24'h0, t0});
	endtask
	// handler epilogue: software clears its flag, then returns
	task fin(input logic [7:0] c);
		if (c != 8'h00) bus(1'h1, OFS_FLAG, {24'h0, c});
		pulse(8'h00, 1'h0, 1'h1);
	endtask
	task done(input string m);
		$display("test %s done", m);
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		{rd, wr, ret, nmi, adr, wd, src} = '0;
		ce = 1'h1;
		n_fail = 0;
		compares = 0;
		dly = 4'h2;
		rst_n = 1'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		for (j = 0; j < 8; j++) rdc(5'(j * 4), 32'h0);
		bus(1'h1, 5'h1C, 32'hFFFFFFFF);
		rdc(5'h1C, 32'h0);
		bus(1'h1, OFS_PRIO, 32'h3CDA);
		rdc(OFS_PRIO, 32'h3CDA);
		done("registers");
		// slow core: offer must stand until taken
		dly <= 4'h9;
		bus(1'h1, OFS_EVMASK, 32'h1);
		bus(1'h1, OFS_ENABLE, 32'h02);
		pulse(8'h02, 1'h0, 1'h0);
		take(16'h000B, 3'h3);
		rdc(OFS_FLAG, 32'h0);
		rdc(OFS_INSERV, 32'h4);
		chk_reg({31'h0, irq}, 32'h1);
		bus(1'h1, OFS_EVMASK, 32'h0);
		repeat (2) @(posedge clk);
		chk_reg({31'h0, irq}, 32'h0);
		bus(1'h1, OFS_EVMASK, 32'h1);
		bus(1'h1, OFS_EVSTAT, 32'hF);
		repeat (2) @(posedge clk);
		chk_reg({31'h0, irq}, 32'h0);
		rdc(OFS_EVSTAT, 32'h0);
		done("timer0");
		dly <= 4'h2;
		bus(1'h1, OFS_ENABLE, 32'h6F);
		pulse(8'h01, 1'h0, 1'h0);
		no_take;
		pulse(8'h08, 1'h0, 1'h0);
		take(16'h001B, 3'h4);
		rdc(OFS_INSERV, 32'hC);
		fin(8'h08);
		no_take;
		rdc(OFS_INSERV, 32'h4);
		fin(8'h00);
		take(16'h0003, 3'h3);
		rdc(OFS_FLAG, 32'h01);
		fin(8'h01);
		rdc(OFS_EVSTAT, 32'h5);
		done("preempt");
		pulse(8'h64, 1'h0, 1'h0);
		take(16'h002B, 3'h4);
		fin(8'h20);
		take(16'h0033, 3'h4);
		fin(8'h40);
		take(16'h0013, 3'h2);
		fin(8'h04);
		done("arbitration");
		pulse(8'h20, 1'h0, 1'h0);
		take(16'h002B, 3'h4);
		pulse(8'h00, 1'h1, 1'h0);
		take(16'h0073, 3'h5);
		rdc(OFS_INSERV, 32'h18);
		fin(8'h00);
		rdc(OFS_INSERV, 32'h08);
		fin(8'h20);
		rdc(OFS_INSERV, 32'h0);
		done("nmi");
		pulse(8'h10, 1'h0, 1'h0);
		no_take;
		rdc(OFS_FLAG, 32'h10);
		bus(1'h1, OFS_ENABLE, 32'h7F);
		take(16'h0023, 3'h1);
		fin(8'h10);
		bus(1'h1, OFS_SWSET, 32'h02);
		take(16'h000B, 3'h3);
		fin(8'h00);
		rdc(OFS_FLAG, 32'h0);
		done("enable");
		// a source pulse while frozen must leave no flag
		@(posedge clk);
		ce <= 1'h0;
		pulse(8'h01, 1'h0, 1'h0);
		@(posedge clk);
		ce <= 1'h1;
		no_take;
		rdc(OFS_FLAG, 32'h0);
		pulse(8'h00, 1'h0, 1'h1);
		rdc(OFS_EVSTAT, 32'hF);
		done("freeze");
		test_done;
	end
endmodule
`default_nettype wire
